// *** hdl/lcd_panel_pin_mux.sv ***
//
// Contract
// - Drive 18-bit panel data bus out.
// - Frame pin: frame pulse or vertical start.
// - Line pin: line pulse or latch pulse.
// - Shift pin: pixel clock or source clock.
// - Ready pin: enable, shift2, bias or level.
// - Direct mode: pins 0-3 carry panel controls when configured as outputs.
// - Pins float in reset, inputs afterwards.
// - Pins 4-7 serve USB pull-up, sense, data.
// - USB interrupt held high until serviced or masked.
// - PWM pin: generated clock or level.
// - Reset restores registers, outputs go inactive.
//
`timescale 1ns/1ps
`default_nettype none

module lcd_panel_pin_mux (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // AXI4-Lite register slave.
  input wire logic [lcd_pin_pkg::AXI_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [lcd_pin_pkg::AXI_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Internal panel timing and USB engines.
  input wire lcd_pin_pkg::panel_timing_t timing,
  input wire lcd_pin_pkg::direct_tft_t direct,
  input wire lcd_pin_pkg::usb_drive_t usb_drive,
  output var lcd_pin_pkg::usb_sense_t usb_sense,
  // USB link clock and interrupt source.
  input wire logic usb_link_clk,
  input wire logic usb_irq_src,
  // Panel pins.
  output logic [17:0] panel_data_out,
  output logic frame_pulse_out,
  output logic line_pulse_out,
  output logic pixel_shift_clock_out,
  output logic display_enable_out,
  // General purpose pins.
  input wire logic [7:0] gpio_pin_in,
  output logic [7:0] gpio_pin_out,
  output logic [7:0] gpio_pin_oe,
  // Interrupt and PWM pins.
  output logic usb_interrupt_out,
  output logic pwm_clock_pin
);

  // ------------------------------------------------------------
  // Address decode.
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    SEL_NONE, SEL_MODE, SEL_GPIO_OUT, SEL_GPIO_CFG, SEL_GPIO_IN,
    SEL_PWM, SEL_STATUS, SEL_MASK, SEL_SVC_A, SEL_SVC_B
  } reg_sel_t;

  function automatic reg_sel_t decode_addr(input logic [lcd_pin_pkg::AXI_ADDR_W-1:0] addr);
    reg_sel_t sel;
    sel = SEL_NONE;
    if (addr[1:0] == 2'h0) begin
      case (addr[17:2])
        lcd_pin_pkg::IDX_PANEL_MODE: sel = SEL_MODE;
        lcd_pin_pkg::IDX_GPIO_OUT: sel = SEL_GPIO_OUT;
        lcd_pin_pkg::IDX_GPIO_CFG: sel = SEL_GPIO_CFG;
        lcd_pin_pkg::IDX_GPIO_IN: sel = SEL_GPIO_IN;
        lcd_pin_pkg::IDX_PWM_CFG: sel = SEL_PWM;
        lcd_pin_pkg::IDX_IRQ_STATUS: sel = SEL_STATUS;
        lcd_pin_pkg::IDX_IRQ_MASK: sel = SEL_MASK;
        lcd_pin_pkg::IDX_USB_SVC_A: sel = SEL_SVC_A;
        lcd_pin_pkg::IDX_USB_SVC_B: sel = SEL_SVC_B;
        default: sel = SEL_NONE;
      endcase
    end
    return sel;
  endfunction

  // ------------------------------------------------------------
  // Pin synchronisers, link edge and events.
  // ------------------------------------------------------------
  logic [9:0] pins_s;
  logic link_prev_reg, link_prev_next;
  logic src_prev_reg, src_prev_next;
  logic cable_prev_reg, cable_prev_next;
  logic link_rise, usb_evt, cable_evt;

  pin_sync #(.WIDTH(10)) u_pin_sync (
    .clk(clk),
    .rst(rst),
    .d({usb_irq_src, usb_link_clk, gpio_pin_in}),
    .q(pins_s)
  );

  // The source is only trusted at link clock rising edges, as the USB engine launches it there.
  always_comb begin
    link_rise = pins_s[8] & ~link_prev_reg;
    usb_evt = link_rise & pins_s[9] & ~src_prev_reg;
    cable_evt = (pins_s[lcd_pin_pkg::GPIO_USB_SENSE] != cable_prev_reg);
    link_prev_next = pins_s[8];
    src_prev_next = link_rise ? pins_s[9] : src_prev_reg;
    cable_prev_next = pins_s[lcd_pin_pkg::GPIO_USB_SENSE];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      link_prev_reg <= 1'b0;
      src_prev_reg <= 1'b0;
      cable_prev_reg <= 1'b0;
    end else begin
      link_prev_reg <= link_prev_next;
      src_prev_reg <= src_prev_next;
      cable_prev_reg <= cable_prev_next;
    end
  end

  // ------------------------------------------------------------
  // Bus slave and register file.
  // ------------------------------------------------------------
  logic awready_reg, awready_next, wready_reg, wready_next;
  logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
  logic [lcd_pin_pkg::AXI_ADDR_W-1:0] waddr_reg, waddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic bvalid_reg, bvalid_next, arready_reg, arready_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [7:0] mode_reg, mode_next, gpo_reg, gpo_next, cfg_reg, cfg_next;
  logic [7:0] status_reg, status_next, mask_reg, mask_next, clr;
  logic [15:0] pwm_cfg_reg, pwm_cfg_next;
  logic wr_fire, ar_fire, lo_en;
  reg_sel_t wsel, rsel;

  always_comb begin
    wr_fire = aw_have_reg & w_have_reg & ~bvalid_reg;
    ar_fire = arvalid & arready_reg;
    wsel = decode_addr(waddr_reg);
    rsel = decode_addr(araddr);
    lo_en = wr_fire & wstrb_reg[0];
    waddr_next = (awvalid & awready_reg) ? awaddr : waddr_reg;
    wdata_next = (wvalid & wready_reg) ? wdata : wdata_reg;
    wstrb_next = (wvalid & wready_reg) ? wstrb : wstrb_reg;
    aw_have_next = aw_have_reg ? ~wr_fire : (awvalid & awready_reg);
    w_have_next = w_have_reg ? ~wr_fire : (wvalid & wready_reg);
    bvalid_next = wr_fire | (bvalid_reg & ~bready);
    bresp_next = bresp_reg;
    if (wr_fire) begin
      bresp_next = (wsel == SEL_NONE) ? lcd_pin_pkg::RESP_SLVERR : lcd_pin_pkg::RESP_OKAY;
    end
    awready_next = ~aw_have_next & ~bvalid_next;
    wready_next = ~w_have_next & ~bvalid_next;
    rvalid_next = ar_fire | (rvalid_reg & ~rready);
    arready_next = ~rvalid_next;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (ar_fire) begin
      rresp_next = lcd_pin_pkg::RESP_OKAY;
      case (rsel)
        SEL_MODE: rdata_next = {24'h000000, mode_reg};
        SEL_GPIO_OUT: rdata_next = {24'h000000, gpo_reg};
        SEL_GPIO_CFG: rdata_next = {24'h000000, cfg_reg};
        SEL_GPIO_IN: rdata_next = {24'h000000, pins_s[7:0]};
        SEL_PWM: rdata_next = {16'h0000, pwm_cfg_reg};
        SEL_STATUS: rdata_next = {24'h000000, status_reg};
        SEL_MASK: rdata_next = {24'h000000, mask_reg};
        SEL_SVC_A, SEL_SVC_B: rdata_next = {31'h00000000, status_reg[lcd_pin_pkg::IRQ_USB_BIT]};
        default: begin
          rdata_next = 32'h00000000;
          rresp_next = lcd_pin_pkg::RESP_SLVERR;
        end
      endcase
    end
    mode_next = (lo_en && wsel == SEL_MODE) ? wdata_reg[7:0] : mode_reg;
    gpo_next = (lo_en && wsel == SEL_GPIO_OUT) ? wdata_reg[7:0] : gpo_reg;
    cfg_next = (lo_en && wsel == SEL_GPIO_CFG) ? wdata_reg[7:0] : cfg_reg;
    mask_next = (lo_en && wsel == SEL_MASK) ? wdata_reg[7:0] : mask_reg;
    pwm_cfg_next = pwm_cfg_reg;
    if (lo_en && wsel == SEL_PWM) begin
      pwm_cfg_next[7:0] = wdata_reg[7:0];
    end
    if (wr_fire && wstrb_reg[1] && wsel == SEL_PWM) begin
      pwm_cfg_next[15:8] = wdata_reg[15:8];
    end
    // Servicing at either USB register clears the same pending flag; a new event wins.
    clr = 8'h00;
    if (lo_en && wsel == SEL_STATUS) begin
      clr = wdata_reg[7:0];
    end
    if (lo_en && (wsel == SEL_SVC_A || wsel == SEL_SVC_B)) begin
      clr[lcd_pin_pkg::IRQ_USB_BIT] = wdata_reg[lcd_pin_pkg::IRQ_USB_BIT];
    end
    status_next = (status_reg & ~clr) | {6'h00, cable_evt, usb_evt};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      waddr_reg <= '0;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= lcd_pin_pkg::RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rresp_reg <= lcd_pin_pkg::RESP_OKAY;
      rdata_reg <= 32'h00000000;
      mode_reg <= lcd_pin_pkg::MODE_RST;
      gpo_reg <= lcd_pin_pkg::GPIO_OUT_RST;
      cfg_reg <= lcd_pin_pkg::GPIO_CFG_RST;
      pwm_cfg_reg <= lcd_pin_pkg::PWM_CFG_RST;
      status_reg <= 8'h00;
      mask_reg <= lcd_pin_pkg::IRQ_MASK_RST;
    end else begin
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      waddr_reg <= waddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
      mode_reg <= mode_next;
      gpo_reg <= gpo_next;
      cfg_reg <= cfg_next;
      pwm_cfg_reg <= pwm_cfg_next;
      status_reg <= status_next;
      mask_reg <= mask_next;
    end
  end

  // ------------------------------------------------------------
  // Pin multiplexer.
  // ------------------------------------------------------------
  lcd_pin_pkg::panel_kind_t kind;
  logic [17:0] data_reg, data_next;
  logic frame_reg, frame_next, line_reg, line_next, shift_reg, shift_next;
  logic ready_reg, ready_next, irq_reg, irq_next, pwm_reg, pwm_next, pwm_wave;
  logic [7:0] gout_reg, gout_next, goe_reg, goe_next;
  lcd_pin_pkg::usb_sense_t sense_reg, sense_next;
  logic [3:0] direct_bits;
  logic usb_mode;

  pwm_gen u_pwm_gen (
    .clk(clk),
    .rst(rst),
    .period(pwm_cfg_reg[lcd_pin_pkg::PWM_PERIOD_LSB +: 8]),
    .duty(pwm_cfg_reg[lcd_pin_pkg::PWM_DUTY_LSB +: 8]),
    .pwm(pwm_wave)
  );

  always_comb begin
    kind = lcd_pin_pkg::panel_kind_t'(mode_reg[lcd_pin_pkg::MODE_KIND_LSB +: 2]);
    usb_mode = mode_reg[lcd_pin_pkg::MODE_USB_FUNC_BIT];
    direct_bits = {direct.source_start_pulse, direct.polarity_reversal,
                   direct.gate_control_signal, direct.panel_power_save};
    data_next = timing.data;
    frame_next = (kind == lcd_pin_pkg::PANEL_DIRECT_TFT) ? direct.vertical_start_pulse
                                                         : timing.frame;
    line_next = (kind == lcd_pin_pkg::PANEL_DIRECT_TFT) ? direct.latch_pulse : timing.line;
    shift_next = (kind == lcd_pin_pkg::PANEL_DIRECT_TFT) ? direct.source_clock
                                                         : timing.shift;
    case (kind)
      lcd_pin_pkg::PANEL_TFT: ready_next = timing.enable;
      lcd_pin_pkg::PANEL_PASSIVE_FMT1: ready_next = timing.second_shift_clock;
      default: ready_next = timing.backplane_bias_toggle;
    endcase
    if (mode_reg[lcd_pin_pkg::MODE_DISPLAY_ENABLE_OUT_GPO_BIT]) begin
      ready_next = mode_reg[lcd_pin_pkg::MODE_DISPLAY_ENABLE_OUT_LEVEL_BIT];
    end
    // A pin drives only when software made it an output, except in USB mode, where pins 4-7 take fixed or USB engine directions; an input pin never floats our side.
    for (int i = 0; i < 8; i++) begin
      gout_next[i] = gpo_reg[i];
      goe_next[i] = cfg_reg[i];
    end
    if (kind == lcd_pin_pkg::PANEL_DIRECT_TFT) begin
      gout_next[3:0] = direct_bits;
    end
    if (usb_mode) begin
      gout_next[lcd_pin_pkg::GPIO_USB_PULLUP] = usb_drive.usb_pullup_control;
      goe_next[lcd_pin_pkg::GPIO_USB_PULLUP] = 1'b1;
      goe_next[lcd_pin_pkg::GPIO_USB_SENSE] = 1'b0;
      gout_next[lcd_pin_pkg::GPIO_USB_MINUS] = usb_drive.minus_out;
      goe_next[lcd_pin_pkg::GPIO_USB_MINUS] = usb_drive.minus_oe;
      gout_next[lcd_pin_pkg::GPIO_USB_PLUS] = usb_drive.plus_out;
      goe_next[lcd_pin_pkg::GPIO_USB_PLUS] = usb_drive.plus_oe;
    end
    sense_next.usb_cable_sense = pins_s[lcd_pin_pkg::GPIO_USB_SENSE] & usb_mode;
    sense_next.usb_minus_line = pins_s[lcd_pin_pkg::GPIO_USB_MINUS] & usb_mode;
    sense_next.usb_plus_line = pins_s[lcd_pin_pkg::GPIO_USB_PLUS] & usb_mode;
    irq_next = |(status_next & mask_next);
    pwm_next = mode_reg[lcd_pin_pkg::MODE_PWM_CLOCK_BIT] ? pwm_wave
                                                         : mode_reg[lcd_pin_pkg::MODE_PWM_LEVEL_BIT];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      data_reg <= 18'h00000;
      frame_reg <= 1'b0;
      line_reg <= 1'b0;
      shift_reg <= 1'b0;
      ready_reg <= 1'b0;
      gout_reg <= 8'h00;
      goe_reg <= 8'h00;
      sense_reg <= '0;
      irq_reg <= 1'b0;
      pwm_reg <= 1'b0;
    end else begin
      data_reg <= data_next;
      frame_reg <= frame_next;
      line_reg <= line_next;
      shift_reg <= shift_next;
      ready_reg <= ready_next;
      gout_reg <= gout_next;
      goe_reg <= goe_next;
      sense_reg <= sense_next;
      irq_reg <= irq_next;
      pwm_reg <= pwm_next;
    end
  end

  assign awready = awready_reg;
  assign wready = wready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rresp = rresp_reg;
  assign rdata = rdata_reg;
  assign panel_data_out = data_reg;
  assign frame_pulse_out = frame_reg;
  assign line_pulse_out = line_reg;
  assign pixel_shift_clock_out = shift_reg;
  assign display_enable_out = ready_reg;
  assign gpio_pin_out = gout_reg;
  assign gpio_pin_oe = goe_reg;
  assign usb_sense = sense_reg;
  assign usb_interrupt_out = irq_reg;
  assign pwm_clock_pin = pwm_reg;

  // ------------------------------------------------------------
  // Assertions.
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_panel_data_pass: assert property (!$past(rst) |-> panel_data_out == $past(timing.data))
    else $error("Panel data not passed through.");
  a_frame_pin_select: assert property (
    !$past(rst) && $past(kind) == lcd_pin_pkg::PANEL_DIRECT_TFT
    |-> frame_pulse_out == $past(direct.vertical_start_pulse))
    else $error("Frame pin not carrying vertical start.");
  a_line_pin_select: assert property (
    !$past(rst) && $past(kind) != lcd_pin_pkg::PANEL_DIRECT_TFT
    |-> line_pulse_out == $past(timing.line))
    else $error("Line pin not carrying line pulse.");
  a_shift_pin_select: assert property (
    !$past(rst) && $past(kind) == lcd_pin_pkg::PANEL_DIRECT_TFT
    |-> pixel_shift_clock_out == $past(direct.source_clock))
    else $error("Shift pin not carrying source clock.");
  a_ready_pin_level: assert property (
    mode_reg[lcd_pin_pkg::MODE_DISPLAY_ENABLE_OUT_GPO_BIT] && !wr_fire
    |=> display_enable_out == $past(mode_reg[lcd_pin_pkg::MODE_DISPLAY_ENABLE_OUT_LEVEL_BIT]))
    else $error("Ready pin not showing its level.");
  a_direct_gpio_map: assert property (
    kind == lcd_pin_pkg::PANEL_DIRECT_TFT && cfg_reg[1]
    |=> gpio_pin_oe[1] && gpio_pin_out[1] == $past(direct.gate_control_signal))
    else $error("Pin 1 not carrying gate control.");
  a_gpio_reset_float: assert property (@(posedge clk) disable iff (1'b0)
    rst |=> gpio_pin_oe == 8'h00)
    else $error("General pin driven during reset.");
  a_usb_pin_map: assert property (usb_mode |=> !gpio_pin_oe[lcd_pin_pkg::GPIO_USB_SENSE]
    && gpio_pin_oe[lcd_pin_pkg::GPIO_USB_PULLUP])
    else $error("USB pin directions wrong.");
  a_usb_irq_raise: assert property (usb_evt && mask_reg[0] && !wr_fire |=> usb_interrupt_out)
    else $error("USB interrupt not raised.");
  a_usb_irq_hold: assert property (usb_interrupt_out && !wr_fire |=> usb_interrupt_out)
    else $error("USB interrupt dropped without service.");
  a_pwm_level_out: assert property (
    !mode_reg[lcd_pin_pkg::MODE_PWM_CLOCK_BIT] && !wr_fire
    |=> pwm_clock_pin == $past(mode_reg[lcd_pin_pkg::MODE_PWM_LEVEL_BIT]))
    else $error("PWM pin not showing its level.");
  a_reset_outputs_low: assert property (@(posedge clk) disable iff (1'b0)
    rst |=> !frame_pulse_out && !line_pulse_out && !usb_interrupt_out && !pwm_clock_pin
    && panel_data_out == 18'h00000 && !display_enable_out && !pixel_shift_clock_out)
    else $error("Outputs not low after reset.");

  c_direct_mode: cover property (kind == lcd_pin_pkg::PANEL_DIRECT_TFT && cfg_reg[3:0] == 4'hF);
  c_irq_serviced: cover property (usb_interrupt_out ##1 !usb_interrupt_out);
  c_write_done: cover property (bvalid && bready);

endmodule // lcd_panel_pin_mux

`default_nettype wire

// *** hdl/lcd_pin_pkg.sv ***
package lcd_pin_pkg;

  // ------------------------------------------------------------
  // Register map: word indices, byte address is four times each.
  // ------------------------------------------------------------
  localparam int AXI_ADDR_W = 18;
  localparam logic [15:0] IDX_PANEL_MODE = 16'h0000;
  localparam logic [15:0] IDX_GPIO_OUT = 16'h0060;
  localparam logic [15:0] IDX_GPIO_CFG = 16'h0064;
  localparam logic [15:0] IDX_GPIO_IN = 16'h0068;
  localparam logic [15:0] IDX_PWM_CFG = 16'h0070;
  localparam logic [15:0] IDX_IRQ_STATUS = 16'h0080;
  localparam logic [15:0] IDX_IRQ_MASK = 16'h0084;
  localparam logic [15:0] IDX_USB_SVC_A = 16'h404A;
  localparam logic [15:0] IDX_USB_SVC_B = 16'h404C;

  // ------------------------------------------------------------
  // Field positions.
  // ------------------------------------------------------------
  localparam int MODE_KIND_LSB = 0;
  localparam int MODE_DISPLAY_ENABLE_OUT_GPO_BIT = 2;
  localparam int MODE_DISPLAY_ENABLE_OUT_LEVEL_BIT = 3;
  localparam int MODE_USB_FUNC_BIT = 4;
  localparam int MODE_PWM_CLOCK_BIT = 5;
  localparam int MODE_PWM_LEVEL_BIT = 6;
  localparam int PWM_PERIOD_LSB = 0;
  localparam int PWM_DUTY_LSB = 8;
  localparam int IRQ_USB_BIT = 0;
  localparam int IRQ_CABLE_BIT = 1;
  localparam int GPIO_USB_PULLUP = 4;
  localparam int GPIO_USB_SENSE = 5;
  localparam int GPIO_USB_MINUS = 6;
  localparam int GPIO_USB_PLUS = 7;

  // ------------------------------------------------------------
  // Reset values and bus answers.
  // ------------------------------------------------------------
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] GPIO_OUT_RST = 8'h00;
  localparam logic [7:0] GPIO_CFG_RST = 8'h00;
  localparam logic [15:0] PWM_CFG_RST = 16'h0000;
  localparam logic [7:0] IRQ_MASK_RST = 8'h01;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ------------------------------------------------------------
  // Types.
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    PANEL_PASSIVE,
    PANEL_PASSIVE_FMT1,
    PANEL_TFT,
    PANEL_DIRECT_TFT
  } panel_kind_t;

  typedef struct packed {
    logic [17:0] data;
    logic frame;
    logic line;
    logic shift;
    logic enable;
    logic second_shift_clock;
    logic backplane_bias_toggle;
  } panel_timing_t;

  typedef struct packed {
    logic vertical_start_pulse;
    logic latch_pulse;
    logic source_clock;
    logic panel_power_save;
    logic gate_control_signal;
    logic polarity_reversal;
    logic source_start_pulse;
  } direct_tft_t;

  typedef struct packed {
    logic usb_pullup_control;
    logic minus_out;
    logic minus_oe;
    logic plus_out;
    logic plus_oe;
  } usb_drive_t;

  typedef struct packed {
    logic usb_cable_sense;
    logic usb_minus_line;
    logic usb_plus_line;
  } usb_sense_t;

endpackage

// *** hdl/pin_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Asynchronous levels in, synchronised levels out.
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // The first stage feeds only the second; nothing else may look at it.
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= d;
      sync_reg <= meta_reg;
    end
  end

  assign q = sync_reg;

endmodule // pin_sync

`default_nettype wire

// *** hdl/pwm_gen.sv ***
`timescale 1ns/1ps
`default_nettype none

module pwm_gen (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Shape of the wave in clock cycles.
  input wire logic [7:0] period,
  input wire logic [7:0] duty,
  // Wave out.
  output logic pwm
);

  logic [7:0] count_reg;
  logic [7:0] count_next;
  logic pwm_reg;
  logic pwm_next;

  // A zero period parks the wave low rather than running a zero-length cycle.
  always_comb begin
    count_next = (count_reg >= period) ? 8'h00 : 8'(count_reg + 8'h01);
    pwm_next = (period != 8'h00) && (count_reg < duty);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= 8'h00;
      pwm_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      pwm_reg <= pwm_next;
    end
  end

  assign pwm = pwm_reg;

endmodule // pwm_gen

`default_nettype wire

// *** testbench/panel_usb_far.sv ***
`timescale 1ns/1ps
`default_nettype none

module panel_usb_far (
  // Pins from the block.
  input wire logic [7:0] gpio_pin_out,
  input wire logic [7:0] gpio_pin_oe,
  // Pins towards the block.
  output logic [7:0] gpio_pin_in,
  output logic usb_link_clk
);
  // ------------------------------------------------------------
  // Board pulls and cable clock.
  // ------------------------------------------------------------
  // Weak pull-downs keep an undriven pin from floating.
  assign gpio_pin_in = gpio_pin_oe & gpio_pin_out;
  // The USB clock runs free, so it is not stopped between frames.
  initial usb_link_clk = 1'b0;
  always #16 usb_link_clk = ~usb_link_clk;
endmodule // panel_usb_far

`default_nettype wire

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [17:0] awaddr = 18'h0, araddr = 18'h0, panel_data_out;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic usb_irq_src = 1'b0, usb_link_clk, awready, wready, bvalid, arready, rvalid;
  logic frame_pulse_out, line_pulse_out, pixel_shift_clock_out, display_enable_out;
  logic usb_interrupt_out, pwm_clock_pin;
  logic [31:0] wdata = 32'h0, rdata, v;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp;
  logic [7:0] gpio_pin_in, gpio_pin_out, gpio_pin_oe;
  lcd_pin_pkg::panel_timing_t timing = '0;
  lcd_pin_pkg::direct_tft_t direct = '0;
  lcd_pin_pkg::usb_drive_t usb_drive = '0;
  lcd_pin_pkg::usb_sense_t usb_sense;
  int errors = 0, checked = 0, seed = 89852, cycles = 0, n;

  lcd_panel_pin_mux lcd_panel_pin_mux_i (.*);
  panel_usb_far panel_usb_far_i (.*);

  always #2 clk = ~clk;

  // ------------------------------------------------------------
  // Bus cycles, comparison and verdict.
  // ------------------------------------------------------------
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task give_verdict;
    if (errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task wr(input logic [15:0] idx, input logic [31:0] d);
    @(posedge clk);
    awaddr <= {idx, 2'b00};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask

  task rd(input logic [15:0] idx, output logic [31:0] d);
    @(posedge clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    rready <= 1'b0;
  endtask

  // Expected panel pins {data, frame, line, shift, ready} for a mode.
  function automatic logic [21:0] pins(input logic [3:0] m,
      input lcd_pin_pkg::panel_timing_t t, input lcd_pin_pkg::direct_tft_t d);
    logic r;
    case (m[1:0])
      2'h1: r = t.second_shift_clock;
      2'h2: r = t.enable;
      default: r = t.backplane_bias_toggle;
    endcase
    if (m[2]) r = m[3];
    if (m[1:0] == 2'h3) return {t.data, d.vertical_start_pulse, d.latch_pulse, d.source_clock, r};
    return {t.data, t.frame, t.line, t.shift, r};
  endfunction

  // A normal run takes far fewer cycles than this ceiling.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      errors++;
      give_verdict();
    end
  end

  // ------------------------------------------------------------
  // Scenarios.
  // ------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk) timing <= 24'($random(seed));
    chk({panel_data_out, frame_pulse_out, usb_interrupt_out, pwm_clock_pin, gpio_pin_oe}, 0);
    repeat (15) @(posedge clk);
    rst <= 1'b0;
    rd(lcd_pin_pkg::IDX_GPIO_CFG, v);
    chk({v, gpio_pin_oe}, 0);
    wr(16'h0004, 32'h1);
    rd(16'h0004, v);
    chk({bresp, rresp, v}, {lcd_pin_pkg::RESP_SLVERR, lcd_pin_pkg::RESP_SLVERR, 32'h0});
    rd(lcd_pin_pkg::IDX_IRQ_MASK, v);
    chk({rresp, v}, {lcd_pin_pkg::RESP_OKAY, 32'h1});
    for (n = 0; n < 40; n++) begin
      v = $random(seed);
      wr(lcd_pin_pkg::IDX_PANEL_MODE, {28'h0, v[3:2], 2'(n)});
      @(posedge clk) timing <= 24'($random(seed));
      direct <= 7'($random(seed));
      repeat (2) @(posedge clk);
      #1 chk({panel_data_out, frame_pulse_out, line_pulse_out, pixel_shift_clock_out,
        display_enable_out}, pins({v[3:2], 2'(n)}, timing, direct));
    end
    wr(lcd_pin_pkg::IDX_GPIO_OUT, 32'hA5);
    wr(lcd_pin_pkg::IDX_GPIO_CFG, 32'hFF);
    wr(lcd_pin_pkg::IDX_PANEL_MODE, 32'h0);
    // The pins pass three flip-flops, the output register and the two-stage synchroniser, so let the last mode change settle first.
    repeat (4) @(posedge clk);
    rd(lcd_pin_pkg::IDX_GPIO_IN, v);
    chk({gpio_pin_oe, v}, 40'hFF_000000A5);
    wr(lcd_pin_pkg::IDX_GPIO_CFG, 32'h0F);
    wr(lcd_pin_pkg::IDX_PANEL_MODE, 32'h13);
    @(posedge clk) direct <= 7'h05;
    usb_drive <= 5'h13;
    repeat (3) @(posedge clk);
    #1 chk({gpio_pin_oe[5:0], gpio_pin_out[4:0]}, 11'h3FA);
    @(posedge clk) usb_irq_src <= 1'b1;
    for (n = 0; n < 40 && usb_interrupt_out !== 1'b1; n++) @(posedge clk);
    repeat (20) @(posedge clk);
    chk(usb_interrupt_out, 1'b1);
    chk(usb_sense, 3'h1);
    wr(lcd_pin_pkg::IDX_USB_SVC_A, 32'h1);
    #1 chk(usb_interrupt_out, 1'b0);
    wr(lcd_pin_pkg::IDX_IRQ_MASK, 32'h0);
    usb_irq_src <= 1'b0;
    repeat (16) @(posedge clk);
    usb_irq_src <= 1'b1;
    repeat (40) @(posedge clk);
    rd(lcd_pin_pkg::IDX_USB_SVC_B, v);
    chk({v[0], usb_interrupt_out}, 2'b10);
    wr(lcd_pin_pkg::IDX_USB_SVC_B, 32'h1);
    rd(lcd_pin_pkg::IDX_USB_SVC_B, v);
    chk(v, 32'h0);
    rd(lcd_pin_pkg::IDX_IRQ_STATUS, v);
    chk(v, 32'h2);
    wr(lcd_pin_pkg::IDX_IRQ_STATUS, 32'h2);
    rd(lcd_pin_pkg::IDX_IRQ_STATUS, v);
    chk(v, 32'h0);
    wr(lcd_pin_pkg::IDX_PANEL_MODE, 32'h40);
    #1 chk(pwm_clock_pin, 1'b1);
    wr(lcd_pin_pkg::IDX_PWM_CFG, 32'h0203);
    wr(lcd_pin_pkg::IDX_PANEL_MODE, 32'h20);
    repeat (10) @(posedge clk);
    v = 0;
    repeat (8) @(posedge clk) v += pwm_clock_pin;
    chk(v, 32'h4);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk({gpio_pin_oe, usb_interrupt_out, pwm_clock_pin, display_enable_out}, 0);
    @(posedge clk) rst <= 1'b0;
    rd(lcd_pin_pkg::IDX_PWM_CFG, v);
    chk(v, 32'h0);
    give_verdict();
  end
endmodule // tb_top

`default_nettype wire
